// ===== verilog/pim_pkg.sv
// package: constants and types for the priority interrupt module
// What this block does
// - each module serves eight request lines with one eight-bit mask
// - mask bit one disarms its line; zero leaves it armed
// - up to eight modules chained, sixty-four lines at most
// - all lines are sampled every cycle regardless of mask or enables
// - simultaneous requests: highest-priority eligible line wins
// - non-colliding requests are served oldest first
// - request on a disabled module stays pending until enabled
// - system enable off blocks every interrupt to the processor
// - each module has its own enable besides the system enable
// - a line in service cannot deliver a second interrupt
// - clearing a module discards its pending and in-service lines
// - taken interrupt presents vector 0100 to 0177 octal to the core
package pim_pkg;
  // ===========================================================
  // geometry
  localparam int PIM_LINES      = 8;
  localparam int PIM_MAX_MODS   = 8;
  localparam int PIM_AGE_W      = 16;
  // ===========================================================
  // register byte offsets
  localparam logic [7:0] PIM_CTRL_OFF   = 8'h00;
  localparam logic [7:0] PIM_CLEAR_OFF  = 8'h04;
  localparam logic [7:0] PIM_STATUS_OFF = 8'h08;
  localparam logic [7:0] PIM_MASK_BASE  = 8'h20;
  localparam logic [7:0] PIM_PEND_BASE  = 8'h40;
  localparam logic [7:0] PIM_BANK_MSK   = 8'hE0;
  // ===========================================================
  // fields and reset values
  localparam int         PIM_CTRL_SYS_BIT = 0;
  localparam int         PIM_CTRL_MOD_LSB = 8;
  localparam int         PIM_STAT_VEC_LSB = 8;
  localparam int         PIM_STAT_BSY_BIT = 16;
  localparam logic [7:0] PIM_MASK_RST     = 8'hFF;
  localparam logic [7:0] PIM_VEC_BASE     = 8'h40;
  localparam logic [7:0] PIM_VEC_LAST     = 8'hBF;
  // ===========================================================
  // carriers
  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } pim_apb_req_type;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pim_apb_rsp_type;
  typedef enum logic [1:0] {
    PIM_IDLE = 2'b00,
    PIM_REQ  = 2'b01
  } pim_state_type;
endpackage : pim_pkg

// ===== verilog/pim_top.sv
// module: priority interrupt controller with apb register slave
`timescale 1ns/1ps
`default_nettype none
module pim_top
  import pim_pkg::*;
#(
  parameter int NMOD = PIM_MAX_MODS
) (
  // clock and reset
  input  wire logic                       CLK_I,
  input  wire logic                       RESET_I,
  // apb slave
  input  wire pim_apb_req_type            APB_I,
  output var  pim_apb_rsp_type            APB_O,
  // external request lines
  input  wire logic [NMOD*PIM_LINES-1:0]  IRQ_I,
  // processor side
  input  wire logic                       INT_ACK_I,
  output logic                            INT_REQ_O,
  output logic [7:0]                      INT_VECTOR_O
);
  localparam int N  = NMOD * PIM_LINES;
  localparam int IW = $clog2(N);

  // ===========================================================
  // state
  logic [N-1:0]           sync1_reg, sync2_reg, prev_reg;
  logic [N-1:0]           pend_reg, pend_next, ins_reg, ins_next;
  logic [PIM_AGE_W-1:0]   age_reg [N];
  logic [7:0]             mask_reg [NMOD];
  logic                   sys_en_reg;
  logic [NMOD-1:0]        mod_en_reg;
  pim_state_type          state_reg;
  logic [IW-1:0]          cur_reg;
  logic                   req_reg;
  pim_apb_rsp_type        rsp_reg;
  logic [7:0]             vec_reg;

  // ===========================================================
  // decode
  wire         acc     = APB_I.psel & APB_I.penable & ~rsp_reg.pready;
  wire         wr      = acc & APB_I.pwrite;
  wire [2:0]   bank    = APB_I.paddr[4:2];
  wire         hit_ctl = APB_I.paddr == PIM_CTRL_OFF;
  wire         hit_clr = APB_I.paddr == PIM_CLEAR_OFF;
  wire         hit_st  = APB_I.paddr == PIM_STATUS_OFF;
  wire         hit_msk = (APB_I.paddr & PIM_BANK_MSK) == PIM_MASK_BASE
                         && 32'(bank) < NMOD && APB_I.paddr[1:0] == 2'b00;
  wire         hit_pnd = (APB_I.paddr & PIM_BANK_MSK) == PIM_PEND_BASE
                         && 32'(bank) < NMOD && APB_I.paddr[1:0] == 2'b00;
  wire         mapped  = hit_ctl | hit_clr | hit_st | hit_msk | hit_pnd;
  wire         clr_wr  = wr & hit_clr;
  wire [N-1:0] rise    = sync2_reg & ~prev_reg;

  logic [N-1:0] armed, clr_lines, elig;
  logic         any_elig;
  logic [IW-1:0] sel_idx;
  logic [31:0]  rdata;

  always_comb begin
    for (int i = 0; i < N; i++) begin
      armed[i]     = ~mask_reg[i / PIM_LINES][i % PIM_LINES];
      clr_lines[i] = clr_wr & APB_I.pwdata[i / PIM_LINES];
      elig[i]      = pend_reg[i] & armed[i] & mod_en_reg[i / PIM_LINES]
                     & sys_en_reg & ~ins_reg[i];
    end
  end

  // oldest wins, ties to lowest index
  always_comb begin
    logic [PIM_AGE_W-1:0] best;
    best     = '0;
    any_elig = 1'b0;
    sel_idx  = '0;
    for (int i = 0; i < N; i++) begin
      if (elig[i] && (!any_elig || age_reg[i] > best)) begin
        any_elig = 1'b1;
        best     = age_reg[i];
        sel_idx  = IW'(i);
      end
    end
  end

  wire take    = state_reg == PIM_REQ && INT_ACK_I;
  wire still   = elig[cur_reg];
  wire [N-1:0] take_vec = take ? (N'(1) << cur_reg) : '0;

  // pending set wins over clear and acknowledge
  always_comb begin
    pend_next = (pend_reg & ~take_vec & ~clr_lines) | rise;
    ins_next  = (ins_reg & ~clr_lines) | take_vec;
  end

  always_comb begin
    rdata = '0;
    if (hit_ctl) begin
      rdata[PIM_CTRL_SYS_BIT] = sys_en_reg;
      rdata[PIM_CTRL_MOD_LSB +: NMOD] = mod_en_reg;
    end else if (hit_st) begin
      rdata[0] = state_reg == PIM_REQ;
      rdata[PIM_STAT_VEC_LSB +: 8] = vec_reg;
      rdata[PIM_STAT_BSY_BIT] = |ins_reg;
    end else if (hit_msk) begin
      rdata[7:0] = mask_reg[bank];
    end else if (hit_pnd) begin
      rdata[7:0]  = pend_reg[bank*PIM_LINES +: PIM_LINES];
      rdata[15:8] = ins_reg[bank*PIM_LINES +: PIM_LINES];
    end
  end

  // ===========================================================
  // two-stage sampling of every line, every cycle
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end else begin
      sync1_reg <= IRQ_I;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      pend_reg <= '0;
      ins_reg  <= '0;
    end else begin
      pend_reg <= pend_next;
      ins_reg  <= ins_next;
    end
  end

  // arrival ages, restarted on each new arrival
  always_ff @(posedge CLK_I) begin
    for (int i = 0; i < N; i++) begin
      if (RESET_I || rise[i] || !pend_reg[i]) begin
        age_reg[i] <= '0;
      end else if (age_reg[i] != '1) begin
        age_reg[i] <= age_reg[i] + 1'b1;
      end
    end
  end

  // ===========================================================
  // register writes
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      sys_en_reg <= 1'b0;
      mod_en_reg <= '0;
      for (int m = 0; m < NMOD; m++) begin
        mask_reg[m] <= PIM_MASK_RST;
      end
    end else if (wr && hit_ctl) begin
      sys_en_reg <= APB_I.pwdata[PIM_CTRL_SYS_BIT];
      mod_en_reg <= APB_I.pwdata[PIM_CTRL_MOD_LSB +: NMOD];
    end else if (wr && hit_msk) begin
      mask_reg[bank] <= APB_I.pwdata[7:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.pready  <= acc;
      rsp_reg.pslverr <= acc & ~mapped;
      rsp_reg.prdata  <= (acc && !APB_I.pwrite) ? rdata : '0;
    end
  end

  // ===========================================================
  // request and vector toward the core
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state_reg <= PIM_IDLE;
      req_reg   <= 1'b0;
      cur_reg   <= '0;
      vec_reg   <= '0;
    end else begin
      case (state_reg)
        PIM_IDLE: begin
          if (any_elig) begin
            state_reg <= PIM_REQ;
            req_reg   <= 1'b1;
            cur_reg   <= sel_idx;
            vec_reg   <= PIM_VEC_BASE + 8'(sel_idx);
          end
        end
        PIM_REQ: begin
          if (take || !still) begin
            state_reg <= PIM_IDLE;
            req_reg   <= 1'b0;
          end
        end
        default: begin
          state_reg <= PIM_IDLE;
          req_reg   <= 1'b0;
        end
      endcase
    end
  end

  assign APB_O        = rsp_reg;
  assign INT_REQ_O    = req_reg;
  assign INT_VECTOR_O = vec_reg;

  // ===========================================================
  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  AST_SYS_OFF_DROPS: assert property (
    INT_REQ_O && !sys_en_reg && !INT_ACK_I |=> !INT_REQ_O)
    else $error("request stayed up with system enable off");
  AST_MASK_DROPS: assert property (
    INT_REQ_O && !armed[cur_reg] && !INT_ACK_I |=> !INT_REQ_O)
    else $error("disarmed line kept its request");
  AST_MOD_OFF_DROPS: assert property (
    INT_REQ_O && !mod_en_reg[cur_reg / PIM_LINES] && !INT_ACK_I |=> !INT_REQ_O)
    else $error("disabled module kept its request");
  AST_VEC_RANGE: assert property (
    INT_REQ_O |-> INT_VECTOR_O >= PIM_VEC_BASE && INT_VECTOR_O <= PIM_VEC_LAST
                  && INT_VECTOR_O == PIM_VEC_BASE + 8'(cur_reg))
    else $error("vector out of range");
  AST_EDGE_LATCHES: assert property (
    $rose(sync2_reg[0]) |=> pend_reg[0] ##0 pend_reg[0] || $past(pend_reg[0]))
    else $error("edge on line zero not latched");
  AST_ACK_BUSY: assert property (
    INT_REQ_O && INT_ACK_I && !clr_wr |=> ins_reg[$past(cur_reg)] && !INT_REQ_O)
    else $error("acknowledged line not marked busy");
  AST_CLEAR_BUSY: assert property (
    clr_wr && APB_I.pwdata[0] && !INT_ACK_I && !rise[0]
    |=> !ins_reg[0] && !pend_reg[0])
    else $error("clear left line zero busy or pending");
  AST_PICK_SELECTED: assert property (
    !INT_REQ_O ##1 INT_REQ_O |-> cur_reg == $past(sel_idx) && $past(any_elig))
    else $error("request raised for a line not selected");
  AST_APB_ONE_WAIT: assert property (
    APB_I.psel && APB_I.penable && !APB_O.pready |=> APB_O.pready)
    else $error("apb answer late");

  // ===========================================================
  // sampling, holding and service checks
  AST_SCAN_ALL: assert property (
    !$past(RESET_I) |-> sync1_reg == $past(IRQ_I))
    else $error("request lines not sampled every cycle");

  AST_PEND_HOLDS: assert property (
    pend_reg[0] && !take_vec[0] && !clr_lines[0] |=> pend_reg[0])
    else $error("pending line zero lost without acknowledge or clear");

  AST_BUSY_NO_REQ: assert property (
    INT_REQ_O |-> !ins_reg[cur_reg])
    else $error("request raised for a line in service");

  AST_SYS_OFF_QUIET: assert property (
    !INT_REQ_O && !sys_en_reg |=> !INT_REQ_O)
    else $error("request rose with system enable off");

  AST_MOD_OFF_QUIET: assert property (
    !INT_REQ_O && mod_en_reg == '0 |=> !INT_REQ_O)
    else $error("request rose with every module disabled");

  AST_OLDEST_WINS: assert property (
    any_elig && elig[0] |-> age_reg[sel_idx] >= age_reg[0])
    else $error("younger line chosen over line zero");

  AST_ACK_CLEARS_PEND: assert property (
    take && !rise[cur_reg] |=> !pend_reg[$past(cur_reg)])
    else $error("acknowledged line still pending");

  AST_VEC_HELD: assert property (
    INT_REQ_O ##1 INT_REQ_O |-> $stable(INT_VECTOR_O))
    else $error("vector changed while request stood");

  // ===========================================================
  // register bus checks
  AST_PREADY_PULSE: assert property (
    APB_O.pready |=> !APB_O.pready)
    else $error("apb ready stood longer than one cycle");

  AST_ERR_UNMAPPED: assert property (
    APB_O.pslverr |-> APB_O.pready && APB_O.prdata == 32'h0)
    else $error("apb error without ready or with data");

  AST_MASK_WRITE: assert property (
    wr && hit_msk |=> mask_reg[$past(bank)] == $past(APB_I.pwdata[7:0]))
    else $error("mask write did not land");

  COV_TAKE:   cover property (INT_REQ_O && INT_ACK_I);
  COV_WITHDRAW: cover property (INT_REQ_O ##1 !INT_REQ_O && !$past(INT_ACK_I));
  COV_COLLIDE: cover property (rise[0] && rise[1] && sys_en_reg);
  COV_CLEAR:  cover property (clr_wr && |ins_reg);
  COV_HELD_OFF: cover property (rise[0] && !mod_en_reg[0]);
endmodule : pim_top
`default_nettype wire

// ===== tb/pim_core_model.sv
// core model: takes vectored interrupts with a set delay
`timescale 1ns/1ps
`default_nettype none
module pim_core_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // controller side
  input  wire logic       req_i,
  input  wire logic [7:0] vec_i,
  input  wire logic [7:0] dly_i,
  output logic            ack_o,
  // observation
  output logic [7:0]      vec_o,
  output logic [7:0]      num_o
);
  logic [7:0] cnt_reg;
  // ==========
  // acknowledge
  // acknowledge rises dly_i + 1 cycles after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      cnt_reg <= 8'h00;
      vec_o <= 8'h00;
      num_o <= 8'h00;
    end else if (ack_o || !req_i) begin
      ack_o <= 1'b0;
      cnt_reg <= 8'h00;
    end else if (cnt_reg == dly_i) begin
      ack_o <= 1'b1;
      vec_o <= vec_i;
      num_o <= num_o + 8'h01;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule : pim_core_model
`default_nettype wire

// ===== tb/testbench.sv
// testbench: register and interrupt scenarios
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pim_pkg::*;
;
  logic CLK_I, RESET_I, ack, req, err;
  pim_apb_req_type rq;
  pim_apb_rsp_type rs;
  logic [63:0] irq;
  logic [7:0] vec, dly, cvec, cnum;
  logic [31:0] q;
  int bad_count, num_checks;
  pim_top #(.NMOD(8)) u_pim_top (.CLK_I(CLK_I), .RESET_I(RESET_I), .APB_I(rq),
    .APB_O(rs), .IRQ_I(irq), .INT_ACK_I(ack), .INT_REQ_O(req), .INT_VECTOR_O(vec));
  pim_core_model u_pim_core_model (.clk_i(CLK_I), .rst_i(RESET_I), .req_i(req),
    .vec_i(vec), .dly_i(dly), .ack_o(ack), .vec_o(cvec), .num_o(cnum));
  // ==========
  // tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge CLK_I);
    rq <= '{a, 1'b1, 1'b0, w, d};
    @(posedge CLK_I);
    rq.penable <= 1'b1;
    do begin
      @(posedge CLK_I);
    end while (rs.pready !== 1'b1);
    q = rs.prdata;
    err = rs.pslverr;
    rq.psel <= 1'b0;
    rq.penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(q, e);
  endtask : rd
  task automatic pulse(input logic [63:0] m);
    @(posedge CLK_I);
    irq <= irq | m;
    repeat (3) @(posedge CLK_I);
    irq <= irq & ~m;
  endtask : pulse
  task automatic quiet();
    logic f;
    f = 1'b0;
    repeat (20) begin
      @(posedge CLK_I);
      if (req !== 1'b0) f = 1'b1;
    end
    chk({31'h0, f}, 32'h0);
  endtask : quiet
  task automatic got(input logic [7:0] v);
    logic [7:0] k;
    int n;
    k = cnum;
    n = 0;
    while (cnum === k && n < 300) begin
      @(posedge CLK_I);
      n++;
    end
    chk({cnum - k, cvec}, {8'h01, v});
  endtask : got
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // ==========
  // clock and watchdog
  initial begin
    CLK_I = 1'b0;
    forever #12.5 CLK_I = ~CLK_I;
  end
  initial begin
    repeat (20000) @(posedge CLK_I);
    bad_count++;
    finish_test();
  end
  // ==========
  // scenarios
  initial begin
    RESET_I = 1'b1;
    rq = '0;
    irq = '0;
    dly = 8'h02;
    bad_count = 0;
    num_checks = 0;
    repeat (12) @(posedge CLK_I);
    RESET_I <= 1'b0;
    rd(PIM_MASK_BASE, {24'h0, PIM_MASK_RST});
    rd(PIM_CTRL_OFF, 32'h0);
    apb(PIM_MASK_BASE + 8'h1C, 1'b1, 32'h1A5);
    rd(PIM_MASK_BASE + 8'h1C, 32'hA5);
    rd(8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("end registers");
    apb(PIM_CTRL_OFF, 1'b1, 32'hFF01);
    rd(PIM_CTRL_OFF, 32'hFF01);
    apb(PIM_MASK_BASE, 1'b1, 32'h04);
    pulse(64'h4);
    quiet();
    rd(PIM_PEND_BASE, 32'h4);
    apb(PIM_MASK_BASE, 1'b1, 32'h0);
    got(8'h42);
    rd(PIM_PEND_BASE, 32'h400);
    rd(PIM_STATUS_OFF, 32'h0001_4200);
    pulse(64'h4);
    quiet();
    apb(PIM_CLEAR_OFF, 1'b1, 32'h1);
    rd(PIM_PEND_BASE, 32'h0);
    quiet();
    $display("end mask and service");
    dly <= 8'h10;
    apb(PIM_MASK_BASE + 8'h04, 1'b1, 32'h0);
    pulse(64'h10A);
    got(8'h41);
    got(8'h43);
    got(8'h48);
    apb(PIM_CLEAR_OFF, 1'b1, 32'h3);
    $display("end priority");
    apb(PIM_MASK_BASE, 1'b1, 32'hFF);
    pulse(64'h40);
    pulse(64'h01);
    apb(PIM_MASK_BASE, 1'b1, 32'h0);
    got(8'h46);
    got(8'h40);
    apb(PIM_CLEAR_OFF, 1'b1, 32'h1);
    $display("end arrival order");
    apb(PIM_CTRL_OFF, 1'b1, 32'h0001);
    apb(PIM_MASK_BASE + 8'h1C, 1'b1, 32'h0);
    pulse(64'h8000_0000_0000_0000);
    quiet();
    apb(PIM_CTRL_OFF, 1'b1, 32'h8001);
    got(8'h7F);
    $display("end module enable");
    apb(PIM_CTRL_OFF, 1'b1, 32'h8000);
    apb(PIM_CLEAR_OFF, 1'b1, 32'h80);
    pulse(64'h0100_0000_0000_0000);
    quiet();
    apb(PIM_CTRL_OFF, 1'b1, 32'h8001);
    got(8'h78);
    $display("end system enable");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
